/* src/ctm_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the compact timer.
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// R1: Period field 000 means 1024 clocks, 001..111 mean 128 to 896 clocks.
// R2: Comparator P compares the period field with counter bits 9..7 only; the code uses field minus one on bits 9..7 and 7f on bits 6..0.
// R3: Period field zero with P clearing lets the counter overflow at maximum.
// R4: Mode field 00 compare output, 10 PWM, 11 timer/counter, 01 undefined.
// R5: Software turns the timer off before changing the mode field.
// R6: Compare mode A match: 00 no change, 01 low, 10 high, 11 toggle.
// R7: PWM mode: 00 inactive, 01 active, 10 waveform, 11 undefined.
// R8: Software changes the pin function in PWM mode only while timer off.
// R9: Initial level bit sets compare start level, PWM active level, unused otherwise.
// R10: A commanded level equal to the initial level shows no pin change.
// R11: Timer on rising edge returns the pin to the initial level.
// R12: Invert bit inverts the pin; no effect in timer/counter mode.
// R13: Swap bit 0: period field is period; 1: compare A is period.
// R14: Clear select 1 clears on A match; 0 on P match or overflow.
// R15: Clear select has no influence in PWM mode.
// R16: Compare mode, clear select low: both A and P flags are raised.
// R17: Clear select high: only the A flag, never the P flag.
// R18: Clear select high, compare A zero: overflow at 3ff without A flag.
// R19: Compare mode pin changes only on A flag; P matches leave it.
// R20: Software keeps pin control disabled in timer/counter mode.
// R21: Timer on rising edge clears counter; falling edge stops and keeps value.
// R22: Pause bit holds the counter; clearing it resumes from that value.
// R23: Comparator A compares all ten bits of the counter.
// R24: Clock select: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall.
// R25: Each match flag is a one-cycle pulse in the cycle of detection; the code registers it, so the pulse comes one cycle later.
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH
`define CTM_OFF_RUN      12'h000
`define CTM_OFF_MODE     12'h004
`define CTM_OFF_CMPA     12'h008
`define CTM_OFF_COUNT    12'h00c
`define CTM_RST_RUN      8'h00
`define CTM_RST_MODE     8'h00
`define CTM_RST_CMPA     10'h000
`define CTM_BIT_PAUSE    7
`define CTM_BIT_ON       3
`define CTM_BIT_OC       3
`define CTM_BIT_POL      2
`define CTM_BIT_DPX      1
`define CTM_BIT_CCLR     0
`define CTM_CNT_MAX      10'h3ff
`define CTM_DIV_SYS4     6'd3
`define CTM_DIV_H16      6'd15
`define CTM_DIV_H64      6'd63
`define CTM_DIV_SUB      6'd63
`define CTM_RESP_OKAY    2'b00
`define CTM_RESP_SLVERR  2'b10
`endif

/* src/ctm_pkg.sv */
// Types shared by the compact timer modules.
package ctm_pkg;
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'b00,
      CTM_MODE_UND = 2'b01,
      CTM_MODE_PWM = 2'b10,
      CTM_MODE_TC  = 2'b11
   } ctm_mode_t;
   typedef enum logic [2:0] {
      CTM_CK_SYS4 = 3'h0,
      CTM_CK_SYS  = 3'h1,
      CTM_CK_H16  = 3'h2,
      CTM_CK_H64  = 3'h3,
      CTM_CK_SUBA = 3'h4,
      CTM_CK_SUBB = 3'h5,
      CTM_CK_RISE = 3'h6,
      CTM_CK_FALL = 3'h7
   } ctm_clksel_t;
endpackage

/* src/ctm_clk_sel.sv */
// Counter clock enable generator for the compact timer.
`timescale 1ns/100ps
`default_nettype none
`include "ctm_cfg.svh"
module ctm_clk_sel (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic [2:0] clk_sel,
   input  wire logic       ext_clk_in,
   output logic            tick
);
   logic [5:0] div_r;
   logic       ext_r;
   logic       ext_rise;
   logic       ext_fall;
   logic       hit;
   // Internal clocks are derived from the one core clock as enable pulses.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 6'h00;
         ext_r <= 1'b0;
      end else begin
         div_r <= div_r + 6'h01;
         ext_r <= ext_clk_in;
      end
   end
   assign ext_rise = ext_clk_in & ~ext_r;
   assign ext_fall = ~ext_clk_in & ext_r;
   always_comb begin
      case (ctm_pkg::ctm_clksel_t'(clk_sel)) // [R24]
         ctm_pkg::CTM_CK_SYS4: hit = (div_r[1:0] == 2'(`CTM_DIV_SYS4));
         ctm_pkg::CTM_CK_SYS:  hit = 1'b1;
         ctm_pkg::CTM_CK_H16:  hit = (div_r[3:0] == 4'(`CTM_DIV_H16));
         ctm_pkg::CTM_CK_H64:  hit = (div_r == `CTM_DIV_H64);
         ctm_pkg::CTM_CK_SUBA: hit = (div_r == `CTM_DIV_SUB);
         ctm_pkg::CTM_CK_SUBB: hit = (div_r == `CTM_DIV_SUB);
         ctm_pkg::CTM_CK_RISE: hit = ext_rise;
         ctm_pkg::CTM_CK_FALL: hit = ext_fall;
         default:              hit = 1'b0;
      endcase
   end
   assign tick = hit;
endmodule
`default_nettype wire

/* src/ctm_pin_out.sv */
// Output pin level logic of the compact timer.
`timescale 1ns/100ps
`default_nettype none
`include "ctm_cfg.svh"
module ctm_pin_out (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic [1:0] mode,
   input  wire logic [1:0] pin_func,
   input  wire logic       init_lvl,
   input  wire logic       invert,
   input  wire logic       on_rise,
   input  wire logic       match_a_evt,
   input  wire logic       pwm_active,
   output logic            pin_level
);
   logic cmp_lvl_r;
   logic cmp_lvl_nxt;
   logic pwm_lvl;
   logic raw_lvl;
   always_comb begin
      cmp_lvl_nxt = cmp_lvl_r;
      if (on_rise) begin
         cmp_lvl_nxt = init_lvl; // [R11]
      end else if (match_a_evt && mode == ctm_pkg::CTM_MODE_CMP) begin // [R19]
         case (pin_func) // [R6] [R10]
            2'b01:   cmp_lvl_nxt = 1'b0;
            2'b10:   cmp_lvl_nxt = 1'b1;
            2'b11:   cmp_lvl_nxt = ~cmp_lvl_r;
            default: cmp_lvl_nxt = cmp_lvl_r;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmp_lvl_r <= 1'b0;
      end else begin
         cmp_lvl_r <= cmp_lvl_nxt;
      end
   end
   always_comb begin
      case (pin_func) // [R7] [R9]
         2'b00:   pwm_lvl = ~init_lvl;
         2'b01:   pwm_lvl = init_lvl;
         2'b10:   pwm_lvl = pwm_active ? init_lvl : ~init_lvl;
         default: pwm_lvl = ~init_lvl;
      endcase
   end
   assign raw_lvl = (mode == ctm_pkg::CTM_MODE_PWM) ? pwm_lvl : cmp_lvl_r;
   // Timer/counter mode leaves the pin unused, so it parks low.
   assign pin_level = (mode == ctm_pkg::CTM_MODE_TC) ? 1'b0 : (raw_lvl ^ invert); // [R12]
endmodule
`default_nettype wire

/* src/ctm_top.sv */
// Compact ten-bit timer with compare output, PWM and AXI4-Lite registers.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ctm_cfg.svh"
module ctm_top (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        external_clock_pin,
   output logic             timer_output_pin,
   output logic             compare_a_flag,
   output logic             compare_p_flag
);
   // ****************************************************************
   // Register bus
   // ****************************************************************
   logic [7:0]  timer_clock_run_control_r;
   logic [7:0]  timer_mode_output_control_r;
   logic [9:0]  compare_a_value_r;
   logic [11:0] aw_addr_r;
   logic        aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        w_have_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        awready_r;
   logic        wready_r;
   logic        arready_r;
   logic        wr_go;
   logic        wr_run;
   logic        wr_mode;
   logic        wr_cmpa;
   logic        wr_hit;
   logic        rd_go;
   logic [31:0] rd_mux;
   logic        rd_hit;
   logic [9:0]  count_r;
   assign wr_go   = aw_have_r & w_have_r & ~bvalid_r;
   assign wr_run  = wr_go & (aw_addr_r[11:2] == `CTM_OFF_RUN >> 2) & w_strb_r[0];
   assign wr_mode = wr_go & (aw_addr_r[11:2] == `CTM_OFF_MODE >> 2) & w_strb_r[0];
   assign wr_cmpa = wr_go & (aw_addr_r[11:2] == `CTM_OFF_CMPA >> 2);
   assign wr_hit  = (aw_addr_r[11:2] == `CTM_OFF_RUN >> 2)
                  | (aw_addr_r[11:2] == `CTM_OFF_MODE >> 2)
                  | (aw_addr_r[11:2] == `CTM_OFF_CMPA >> 2)
                  | (aw_addr_r[11:2] == `CTM_OFF_COUNT >> 2);
   assign rd_go   = s_axi_arvalid & arready_r;
   assign rd_hit  = (s_axi_araddr[11:2] == `CTM_OFF_RUN >> 2)
                  | (s_axi_araddr[11:2] == `CTM_OFF_MODE >> 2)
                  | (s_axi_araddr[11:2] == `CTM_OFF_CMPA >> 2)
                  | (s_axi_araddr[11:2] == `CTM_OFF_COUNT >> 2);
   assign rd_mux  = (s_axi_araddr[11:2] == `CTM_OFF_RUN >> 2)  ? {24'h0, timer_clock_run_control_r}
                  : (s_axi_araddr[11:2] == `CTM_OFF_MODE >> 2) ? {24'h0, timer_mode_output_control_r}
                  : (s_axi_araddr[11:2] == `CTM_OFF_CMPA >> 2) ? {22'h0, compare_a_value_r}
                  : (s_axi_araddr[11:2] == `CTM_OFF_COUNT >> 2) ? {22'h0, count_r}
                  : 32'h0;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 12'h000;
         awready_r <= 1'b0;
      end else begin
         awready_r <= ~aw_have_r & ~(s_axi_awvalid & awready_r);
         if (s_axi_awvalid & awready_r) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         w_have_r <= 1'b0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         wready_r <= 1'b0;
      end else begin
         wready_r <= ~w_have_r & ~(s_axi_wvalid & wready_r);
         if (s_axi_wvalid & wready_r) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `CTM_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= `CTM_RESP_OKAY;
      end else begin
         arready_r <= ~rvalid_r & ~rd_go;
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_hit ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_clock_run_control_r   <= `CTM_RST_RUN;
         timer_mode_output_control_r <= `CTM_RST_MODE;
         compare_a_value_r           <= `CTM_RST_CMPA;
      end else begin
         if (wr_run) begin
            timer_clock_run_control_r <= w_data_r[7:0];
         end
         if (wr_mode) begin
            timer_mode_output_control_r <= w_data_r[7:0]; // [R5] [R8] [R20]
         end
         if (wr_cmpa) begin
            if (w_strb_r[0]) begin
               compare_a_value_r[7:0] <= w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
               compare_a_value_r[9:8] <= w_data_r[9:8];
            end
         end
      end
   end
   // ****************************************************************
   // Counter and comparators
   // ****************************************************************
   logic       on_r;
   logic       on_rise;
   logic       tick;
   logic       run_en;
   logic [1:0] mode;
   logic [2:0] period_field;
   logic       clr_sel;
   logic       dpx;
   logic       match_a;
   logic       match_p;
   logic       at_max;
   logic       clear_cnt;
   logic       flag_a_nxt;
   logic       flag_p_nxt;
   logic       pwm_active;
   logic [9:0] period_cmp;
   logic       pin_lvl;
   logic       pin_r;
   logic       flag_a_r;
   logic       flag_p_r;
   assign mode         = timer_mode_output_control_r[7:6]; // [R4]
   assign clr_sel      = timer_mode_output_control_r[`CTM_BIT_CCLR];
   assign dpx          = timer_mode_output_control_r[`CTM_BIT_DPX];
   assign period_field = timer_clock_run_control_r[2:0];
   assign on_rise      = timer_clock_run_control_r[`CTM_BIT_ON] & ~on_r;
   assign run_en       = on_r & timer_clock_run_control_r[`CTM_BIT_ON]
                       & ~timer_clock_run_control_r[`CTM_BIT_PAUSE] & tick; // [R21] [R22]
   // Matches are taken on the count value reached, so one event per value.
   assign match_a      = run_en & (count_r == compare_a_value_r)
                       & (compare_a_value_r != 10'h000); // [R23] [R18]
   // P fires on the tick that would carry the count onto the boundary, so the period is exact.
   assign match_p      = run_en & (period_field != 3'h0) & (count_r[6:0] == 7'h7f)
                       & (count_r[9:7] == period_field - 3'h1); // [R1] [R2]
   assign at_max       = run_en & (count_r == `CTM_CNT_MAX);
   always_comb begin
      if (mode == ctm_pkg::CTM_MODE_PWM) begin
         clear_cnt = dpx ? match_a : (match_p | at_max); // [R13] [R15]
      end else if (clr_sel) begin
         clear_cnt = match_a | at_max; // [R14]
      end else begin
         clear_cnt = match_p | at_max; // [R3]
      end
   end
   assign flag_a_nxt = match_a; // [R25]
   assign flag_p_nxt = match_p & (~clr_sel | mode == ctm_pkg::CTM_MODE_PWM); // [R16] [R17]
   assign period_cmp = {period_field, 7'h00};
   // Duty compares the live count; a duty at or past the period stays active.
   assign pwm_active = dpx ? ((period_field == 3'h0) | (count_r < period_cmp))
                           : (count_r < compare_a_value_r);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         on_r    <= 1'b0;
         count_r <= 10'h000;
      end else begin
         on_r <= timer_clock_run_control_r[`CTM_BIT_ON];
         if (on_rise) begin
            count_r <= 10'h000; // [R21]
         end else if (clear_cnt) begin
            count_r <= 10'h000;
         end else if (run_en) begin
            count_r <= count_r + 10'h001;
         end
      end
   end
   ctm_clk_sel u_clk_sel (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .clk_sel    (timer_clock_run_control_r[6:4]),
      .ext_clk_in (external_clock_pin),
      .tick       (tick)
   );
   ctm_pin_out u_pin_out (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .mode        (mode),
      .pin_func    (timer_mode_output_control_r[5:4]),
      .init_lvl    (timer_mode_output_control_r[`CTM_BIT_OC]),
      .invert      (timer_mode_output_control_r[`CTM_BIT_POL]),
      .on_rise     (on_rise),
      .match_a_evt (match_a),
      .pwm_active  (pwm_active),
      .pin_level   (pin_lvl)
   );
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_r    <= 1'b0;
         flag_a_r <= 1'b0;
         flag_p_r <= 1'b0;
      end else begin
         pin_r    <= pin_lvl;
         flag_a_r <= flag_a_nxt;
         flag_p_r <= flag_p_nxt;
      end
   end
   assign s_axi_awready    = awready_r;
   assign s_axi_wready     = wready_r;
   assign s_axi_bvalid     = bvalid_r;
   assign s_axi_bresp      = bresp_r;
   assign s_axi_arready    = arready_r;
   assign s_axi_rvalid     = rvalid_r;
   assign s_axi_rdata      = rdata_r;
   assign s_axi_rresp      = rresp_r;
   assign timer_output_pin = pin_r;
   assign compare_a_flag   = flag_a_r;
   assign compare_p_flag   = flag_p_r;
   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_on_edge;
      $rose(timer_clock_run_control_r[`CTM_BIT_ON]);
   endsequence
   AST_ON_CLEARS: assert property (s_on_edge |=> count_r == 10'h000) // [R21]
      else $error("counter not cleared on timer on");
   AST_PAUSE_HOLD: assert property (timer_clock_run_control_r[`CTM_BIT_PAUSE] && on_r
      && !on_rise |=> $stable(count_r)) // [R22]
      else $error("counter moved while paused");
   AST_A_FLAG: assert property (match_a |=> compare_a_flag) // [R25]
      else $error("compare a flag missing");
   AST_NO_P_FLAG: assert property (clr_sel && mode != ctm_pkg::CTM_MODE_PWM
      |=> !compare_p_flag) // [R17]
      else $error("p flag raised with a clearing");
   AST_P_POINT: assert property (compare_p_flag |-> $past(count_r[6:0]) == 7'h7f) // [R2]
      else $error("p match off a 128 boundary");
   AST_A_ZERO: assert property (compare_a_value_r == 10'h000 |=> !compare_a_flag) // [R18]
      else $error("a flag with zero compare value");
   AST_INIT_LVL: assert property (s_on_edge ##0 (mode == ctm_pkg::CTM_MODE_CMP)
      ##1 $stable(timer_mode_output_control_r) |=> timer_output_pin
      == (timer_mode_output_control_r[`CTM_BIT_OC] ^ timer_mode_output_control_r[`CTM_BIT_POL])) // [R11]
      else $error("pin not at initial level after on");
   AST_MAX_WRAP: assert property (at_max |=> count_r == 10'h000) // [R3]
      else $error("counter did not wrap at maximum");
endmodule
`default_nettype wire

/* verification/ctm_ext_clk_model.sv */
// Board-side model that drives the external counter clock pin.
`timescale 1ns/100ps
`default_nettype none
module ctm_ext_clk_model #(
   parameter int HALF = 4
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic run,
   output logic      ext_clk
);
   int cnt;
   // ****************************************************************
   // Clock source
   // ****************************************************************
   // The board clock rests low between bursts, so stray edges never count.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b || !run) begin
         cnt     <= 0;
         ext_clk <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt     <= 0;
         ext_clk <= ~ext_clk;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

/* verification/compact_timer_compare_output_test.sv */
// Self-checking bench for the compact timer over its register bus and pins.
`timescale 1ns/100ps
`default_nettype none
`include "ctm_cfg.svh"
module compact_timer_compare_output_test;
   logic        core_clk, rst_b, ext_run, external_clock_pin;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_last, g, c;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        timer_output_pin, compare_a_flag, compare_p_flag;
   logic [34:0] rd_q[$];
   logic [1:0]  wr_q[$];
   int          n_fail, samples_checked, cycles;
   int          div_tab[8] = '{4, 1, 16, 64, 64, 64, 8, 8};
   // ****************************************************************
   // Clock, design and board model
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   ctm_top DUT (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_clock_pin,
      .timer_output_pin, .compare_a_flag, .compare_p_flag);
   ctm_ext_clk_model PART (.core_clk, .rst_b, .run(ext_run), .ext_clk(external_clock_pin));
   // ****************************************************************
   // Checking, bus tasks and closing
   // ****************************************************************
   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_fail++;
         print_verdict();
      end
      if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0) begin
         if (rd_q[0][34]) check("read", {s_axi_rresp, s_axi_rdata}, rd_q[0][33:0]);
         void'(rd_q.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready && wr_q.size() > 0) check("bresp", s_axi_bresp, wr_q.pop_front());
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r = `CTM_RESP_OKAY);
      wr_q.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input bit care = 1,
                     input logic [1:0] r = `CTM_RESP_OKAY);
      rd_q.push_back({care, r, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
      rd_last = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask
   function automatic logic [31:0] runv(logic pau, logic [2:0] ck, logic on, logic [2:0] per);
      return {24'h0, pau, ck, on, per};
   endfunction
   // The timer is always switched off before mode or pin function change.
   task automatic cfg(logic [1:0] md, fn, logic oc, pol, dpx, cclr, logic [2:0] ck, per,
                      logic [9:0] a);
      wr(`CTM_OFF_RUN, runv(1'b0, ck, 1'b0, per));
      wr(`CTM_OFF_MODE, {24'h0, md, fn, oc, pol, dpx, cclr});
      wr(`CTM_OFF_CMPA, {22'h0, a});
      wr(`CTM_OFF_RUN, runv(1'b0, ck, 1'b1, per));
   endtask
   task automatic wait_flag(input bit p);
      int t;
      t = 0;
      do begin
         @(posedge core_clk);
         t++;
      end while (!(p ? compare_p_flag : compare_a_flag) && t < 5000);
      if (t >= 5000) n_fail++;
   endtask
   task automatic gap(input bit p, output logic [31:0] n);
      wait_flag(p);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!(p ? compare_p_flag : compare_a_flag) && n < 5000);
   endtask
   // Counts A pulses, P pulses or cycles with the pin at a level.
   task automatic count(input int w, input int what, input logic lvl, output logic [31:0] n);
      n = 0;
      repeat (w) begin
         @(posedge core_clk);
         n += (what == 0) ? compare_a_flag : (what == 1) ? compare_p_flag : (timer_output_pin === lvl);
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished after %0d checks", s, samples_checked);
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] v;
      logic        p, lv;
      {rst_b, ext_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      void'($urandom(32'hc323));
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(`CTM_OFF_RUN, 32'h0);
      rd(`CTM_OFF_MODE, 32'h0);
      rd(`CTM_OFF_CMPA, 32'h0);
      rd(`CTM_OFF_COUNT, 32'h0);
      rd(12'h010, 32'h0, 1, `CTM_RESP_SLVERR);
      wr(12'h010, 32'hff, `CTM_RESP_SLVERR);
      wr(`CTM_OFF_CMPA, 32'hffff_ffff);
      rd(`CTM_OFF_CMPA, 32'h3ff);
      wr(`CTM_OFF_MODE, 32'h9a);
      rd(`CTM_OFF_MODE, 32'h9a);
      done("registers");
      for (int k = 1; k < 8; k++) begin
         cfg(2'b00, 2'b00, 0, 0, 0, 0, 3'h1, k[2:0], 10'h3ff);
         gap(1, g);
         check("period", g, 128 * k);
      end
      cfg(2'b00, 2'b00, 0, 0, 0, 0, 3'h1, 3'h0, 10'd5);
      gap(0, g);
      check("overflow", g, 1024);
      cfg(2'b00, 2'b00, 0, 0, 0, 1, 3'h1, 3'h1, 10'd300);
      count(700, 1, 0, c);
      check("p flags", c, 0);
      gap(0, g);
      check("a clear", g, 301);
      cfg(2'b00, 2'b00, 0, 0, 0, 1, 3'h1, 3'h0, 10'd0);
      count(2100, 0, 0, c);
      check("a zero", c, 0);
      done("clearing");
      ext_run <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         cfg(2'b00, 2'b00, 0, 0, 0, 1, k[2:0], 3'h0, 10'd9);
         gap(0, g);
         check("clock", g, 10 * div_tab[k]);
      end
      ext_run <= 1'b0;
      done("clock select");
      for (int k = 0; k < 8; k++) begin
         p = 1'($urandom);
         lv = (k[1:0] == 0) ? k[2] : (k[1:0] == 1) ? 1'b0 : (k[1:0] == 2) ? 1'b1 : !k[2];
         cfg(2'b00, k[1:0], k[2], p, 0, 0, 3'h1, 3'h2, 10'd200);
         repeat (3) @(posedge core_clk);
         check("pin start", timer_output_pin, k[2] ^ p);
         wait_flag(0);
         repeat (3) @(posedge core_clk);
         check("pin on a", timer_output_pin, lv ^ p);
         wait_flag(1);
         repeat (3) @(posedge core_clk);
         check("pin on p", timer_output_pin, lv ^ p);
      end
      cfg(2'b11, 2'b00, 1, 1, 0, 1, 3'h1, 3'h0, 10'd50);
      gap(0, g);
      check("tc flags", g, 51);
      check("tc pin", timer_output_pin, 0);
      done("compare output");
      for (int k = 0; k < 4; k++) begin
         p = 1'($urandom);
         cfg(2'b10, 2'b10, k[0], p, k[1], k[0], 3'h1, 3'h1, k[1] ? 10'd255 : 10'd32);
         repeat (300) @(posedge core_clk);
         count(512, 2, k[0] ^ p, c);
         check("pwm duty", c, k[1] ? 256 : 128);
      end
      for (int k = 0; k < 2; k++) begin
         cfg(2'b10, k[1:0], 1, 0, 0, 0, 3'h1, 3'h1, 10'd32);
         repeat (10) @(posedge core_clk);
         check("pwm forced", timer_output_pin, k[0]);
      end
      done("pwm");
      cfg(2'b00, 2'b00, 0, 0, 0, 1, 3'h1, 3'h0, 10'd1000);
      repeat (50) @(posedge core_clk);
      wr(`CTM_OFF_RUN, runv(1'b1, 3'h1, 1'b1, 3'h0));
      rd(`CTM_OFF_COUNT, 32'h0, 0);
      v = rd_last;
      repeat (20) @(posedge core_clk);
      rd(`CTM_OFF_COUNT, 32'h0, 0);
      check("pause", rd_last, v);
      wr(`CTM_OFF_RUN, runv(1'b0, 3'h1, 1'b0, 3'h0));
      rd(`CTM_OFF_COUNT, 32'h0, 0);
      v = rd_last;
      repeat (20) @(posedge core_clk);
      rd(`CTM_OFF_COUNT, 32'h0, 0);
      check("off hold", rd_last, v);
      wr(`CTM_OFF_RUN, runv(1'b1, 3'h1, 1'b1, 3'h0));
      rd(`CTM_OFF_COUNT, 32'h0);
      repeat (2) @(posedge core_clk);
      done("pause and restart");
      print_verdict();
   end
endmodule
`default_nettype wire
